/* File: rtl/lrpa_cfg.svh */
// constants for the second-level memory request arbiter
// assumes inclusion by rtl files only; definitions only
`ifndef LRPA_CFG_SVH
`define LRPA_CFG_SVH

`define LRPA_NUM_BANKS        4
`define LRPA_BANK_BITS        64
`define LRPA_BANK_LSB         3
`define LRPA_BLOCK_WORDS      32
`define LRPA_BLOCK_LSB        7
`define LRPA_INVERSION_CYCLES 256
`define LRPA_PRIO_RESET       1'b0

`endif

/* File: rtl/lrpa_pkg.sv */
// types for the second-level memory request arbiter
// assumes byte addresses of 32 bits from both requesters
package lrpa_pkg;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic [63:0] wdata;
        logic [7:0]  be;
    } lrpa_req_t;

    typedef enum logic [1:0] {
        LRPA_IDLE = 2'b00,
        LRPA_INV  = 2'b01,
        LRPA_HOLD = 2'b11
    } lrpa_inv_state_t;

endpackage : lrpa_pkg

/* File: rtl/lrpa_arbiter.sv */
// second-level memory arbiter: data cache store path against transfer
// crossbar, over four interleaved 64-bit banks
// assumes requesters hold a request until granted; one clock domain
// grants are combinational; busy and inversion flags are registered
`timescale 1ns/1ns
`include "lrpa_cfg.svh"

// Summary of operation
// RL1: priority bit set: crossbar beats data cache
// RL2: bit clear: cache stores may starve crossbar
// RL3: bit clear, same bank: cache wins always
// RL4: four interleaved banks, each 64 bits wide
// RL5: same 32-word block: data cache wins until the RL6 bound
// RL6: same-block inversion bounded to 256 cycles
// RL7: software keeps buffers in separate blocks
// RL8: software keeps streaming data on-chip
// RL9: software prefers range cache operations
// RL10: software splits range operations into chunks
// RL11: chunking lengthens total, shortens worst wait
// RL12: priority bit resets to zero
module lrpa_arbiter #(
    parameter int NUM_BANKS  = `LRPA_NUM_BANKS,
    parameter int INV_CYCLES = `LRPA_INVERSION_CYCLES
) (
    input  wire logic              core_clk_in,
    input  wire logic              nrst_in,
    input  wire logic              mem_priority_in,
    input  wire lrpa_pkg::lrpa_req_t cache_req_in,
    input  wire lrpa_pkg::lrpa_req_t xbar_req_in,
    output logic                   cache_grant_out,
    output logic                   xbar_grant_out,
    output logic                   cache_stall_out,
    output logic                   xbar_stall_out,
    output logic [NUM_BANKS-1:0]   bank_busy_out,
    output logic                   inversion_active_out
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    localparam int CNT_W = 12;

    if (NUM_BANKS != `LRPA_NUM_BANKS) begin : g_bad_banks
        $error("lrpa_arbiter: bank count must be four");
    end
    if (INV_CYCLES < 1) begin : g_bad_inv_low
        $error("lrpa_arbiter: inversion bound below one");
    end
    if (INV_CYCLES >= (1 << CNT_W)) begin : g_bad_inv_high
        $error("lrpa_arbiter: inversion bound too wide");
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // copy of reset released on the clock; used by all state
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic [1:0] bank_of(input logic [31:0] a);
        bank_of = a[`LRPA_BANK_LSB +: 2]; // RL4
    endfunction : bank_of

    function automatic logic [24:0] block_of(input logic [31:0] a);
        block_of = a[31:`LRPA_BLOCK_LSB]; // RL5
    endfunction : block_of

    logic same_bank;
    logic same_block;
    logic both;

    assign both       = cache_req_in.valid && xbar_req_in.valid;
    assign same_bank  = both && (bank_of(cache_req_in.addr) ==
                                 bank_of(xbar_req_in.addr));
    assign same_block = both && (block_of(cache_req_in.addr) ==
                                 block_of(xbar_req_in.addr));

    logic block_clash;

    assign block_clash = same_bank && same_block;

    // ------------------------------------------------------------
    // priority bit and inversion bound
    // ------------------------------------------------------------
    logic                      prio_reg;
    logic                      prio_next;
    lrpa_pkg::lrpa_inv_state_t inv_reg;
    lrpa_pkg::lrpa_inv_state_t inv_next;
    logic [11:0]               inv_cnt_reg;
    logic [11:0]               inv_cnt_next;
    logic                      inv_expired;

    // counts cycles while the cache holds a clashing block
    assign inv_expired = (inv_cnt_reg >= 12'(INV_CYCLES - 1));

    always_comb begin
        prio_next    = mem_priority_in;
        inv_next     = inv_reg;
        inv_cnt_next = inv_cnt_reg;
        case (inv_reg)
            lrpa_pkg::LRPA_IDLE: begin
                inv_cnt_next = 12'h000;
                if (prio_reg && block_clash && cache_req_in.write) begin
                    inv_next = lrpa_pkg::LRPA_INV;
                end
            end
            lrpa_pkg::LRPA_INV: begin
                // cache owns the block while the inversion lasts
                if (!block_clash || !prio_reg) begin
                    inv_next = lrpa_pkg::LRPA_IDLE;
                end else if (inv_expired) begin
                    inv_next = lrpa_pkg::LRPA_HOLD; // RL6 RL11
                end else begin
                    inv_cnt_next = inv_cnt_reg + 12'h001;
                end
            end
            lrpa_pkg::LRPA_HOLD: begin
                // crossbar served; worst crossbar wait stays bounded
                if (!block_clash || !prio_reg) begin
                    inv_next = lrpa_pkg::LRPA_IDLE;
                end
            end
            default: inv_next = lrpa_pkg::LRPA_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            prio_reg    <= `LRPA_PRIO_RESET; // RL12
            inv_reg     <= lrpa_pkg::LRPA_IDLE;
            inv_cnt_reg <= 12'h000;
        end else begin
            prio_reg    <= prio_next;
            inv_reg     <= inv_next;
            inv_cnt_reg <= inv_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // grant decision
    // ------------------------------------------------------------
    logic cache_wins;
    logic cache_g;
    logic xbar_g;

    always_comb begin
        cache_wins = 1'b1; // RL3
        if (same_bank) begin
            if (!prio_reg) begin
                cache_wins = 1'b1; // RL2
            end else if (same_block && inv_reg != lrpa_pkg::LRPA_HOLD) begin
                cache_wins = 1'b1; // RL5
            end else begin
                cache_wins = 1'b0; // RL1
            end
        end
        cache_g = 1'b0;
        xbar_g  = 1'b0;
        if (cache_req_in.valid && (!same_bank || cache_wins)) begin
            cache_g = 1'b1;
        end
        if (xbar_req_in.valid && (!same_bank || !cache_wins)) begin
            xbar_g = 1'b1;
        end
    end

    // loser simply retries; nothing is queued here

    assign cache_grant_out = cache_g;
    assign xbar_grant_out  = xbar_g;
    assign cache_stall_out = cache_req_in.valid && !cache_g;
    assign xbar_stall_out  = xbar_req_in.valid && !xbar_g;

    // ------------------------------------------------------------
    // observed state
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0] busy_reg;
    logic [NUM_BANKS-1:0] busy_next;
    logic                 inv_act_reg;
    logic                 inv_act_next;

    always_comb begin
        busy_next = '0;
        if (cache_g) begin
            busy_next[bank_of(cache_req_in.addr)] = 1'b1; // RL4
        end
        if (xbar_g) begin
            busy_next[bank_of(xbar_req_in.addr)] = 1'b1;
        end
        // flag follows the state the counter is in next cycle
        inv_act_next = (inv_next == lrpa_pkg::LRPA_INV);
    end

    always_ff @(posedge core_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            busy_reg    <= '0;
            inv_act_reg <= 1'b0;
        end else begin
            busy_reg    <= busy_next;
            inv_act_reg <= inv_act_next;
        end
    end

    assign bank_busy_out        = busy_reg;
    assign inversion_active_out = inv_act_reg;

endmodule : lrpa_arbiter

/* File: tb/lrpa_req_model.sv */
// requester model for either side of the arbiter
// assumes the bench loads one request at a time
`timescale 1ns/1ns
module lrpa_req_model (
    input  wire logic                core_clk_in,
    input  wire logic                nrst_in,
    input  wire logic                load_in,
    input  wire logic                hold_in,
    input  wire logic                grant_in,
    input  wire lrpa_pkg::lrpa_req_t req_in,
    output lrpa_pkg::lrpa_req_t      req_out
);
    // held until granted; released lines invert
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in)
            req_out <= '0;
        else if (load_in)
            req_out <= req_in;
        else if (grant_in && !hold_in)
            req_out <= {1'b0, ~req_out[104:0]};
    end
endmodule : lrpa_req_model

/* File: tb/lrpa_arbiter_sva.sv */
// assertions on the arbiter ports
// assumes bind onto lrpa_arbiter
`timescale 1ns/1ns
module lrpa_arbiter_sva #(parameter int INV_CYCLES = 256) (
    input wire logic                core_clk_in,
    input wire logic                nrst_in,
    input wire logic                mem_priority_in,
    input wire lrpa_pkg::lrpa_req_t cache_req_in,
    input wire lrpa_pkg::lrpa_req_t xbar_req_in,
    input wire logic                cache_grant_out,
    input wire logic                xbar_grant_out,
    input wire logic                cache_stall_out,
    input wire logic                xbar_stall_out
);
    logic [3:0] sh_reg;
    logic       pr_reg;
    logic [9:0] cnt_reg;
    logic       both, bnk, blk, pr, npr;
    assign both = cache_req_in.valid && xbar_req_in.valid;
    assign bnk = both && cache_req_in.addr[4:3] == xbar_req_in.addr[4:3];
    assign blk = both && cache_req_in.addr[31:7] == xbar_req_in.addr[31:7];
    assign pr = pr_reg && mem_priority_in;
    assign npr = !pr_reg && !mem_priority_in;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sh_reg <= 4'h0;
            pr_reg <= 1'b0;
            cnt_reg <= 10'h000;
        end else begin
            sh_reg <= {sh_reg[2:0], 1'b1};
            pr_reg <= mem_priority_in;
            cnt_reg <= (xbar_stall_out && pr && cache_req_in.write) ?
                       cnt_reg + 10'h001 : 10'h000;
        end
    end
    // ----------------------------
    // assertions
    // ----------------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!sh_reg[3]);
    sequence s_new_clash;
        !blk ##1 (blk && pr && cache_req_in.write);
    endsequence
    a_cache_stall: assert property (cache_stall_out ==
        (cache_req_in.valid && !cache_grant_out)) else $error("cache stall");
    a_xbar_stall: assert property (xbar_stall_out ==
        (xbar_req_in.valid && !xbar_grant_out)) else $error("xbar stall");
    a_split_banks: assert property (both && !bnk |->
        cache_grant_out && xbar_grant_out) else $error("split banks");
    a_bank_excl: assert property (bnk |->
        !(cache_grant_out && xbar_grant_out)) else $error("bank shared");
    a_cache_first: assert property (bnk && npr |->
        cache_grant_out) else $error("cache lost");
    a_xbar_first: assert property (bnk && !blk && pr |->
        xbar_grant_out) else $error("xbar lost");
    a_block_cache: assert property (s_new_clash |->
        cache_grant_out) else $error("block clash");
    a_inv_bound: assert property (cnt_reg <= INV_CYCLES + 4)
        else $error("inversion too long");
endmodule : lrpa_arbiter_sva
bind lrpa_arbiter lrpa_arbiter_sva #(.INV_CYCLES(INV_CYCLES)) sva_i (.*);

/* File: tb/tb_lrpa_arbiter.sv */
// bench for the arbiter, two requester models
// assumes a 250 MHz clock
`timescale 1ns/1ns
module tb_lrpa_arbiter;
    logic core_clk_in = 0, nrst_in = 0, prio = 0, mon = 0, ld = 0, hold = 0;
    int n_mismatch = 0, n_checks = 0, k;
    logic [1:0] q[$], e;
    logic [31:0] a;
    lrpa_pkg::lrpa_req_t cr = '0, xr = '0, cq, xq;
    logic cg, xg, ia;
    logic [3:0] bb;
    always #2 core_clk_in = ~core_clk_in;
    lrpa_req_model lrpa_req_model_i (.core_clk_in, .nrst_in, .load_in(ld),
        .hold_in(hold), .grant_in(cg), .req_in(cr), .req_out(cq));
    lrpa_req_model lrpa_req_model_x_i (.core_clk_in, .nrst_in, .load_in(ld),
        .hold_in(1'b0), .grant_in(xg), .req_in(xr), .req_out(xq));
    lrpa_arbiter #(.INV_CYCLES(8)) lrpa_arbiter_i (.core_clk_in, .nrst_in,
        .mem_priority_in(prio), .cache_req_in(cq), .xbar_req_in(xq),
        .cache_grant_out(cg), .xbar_grant_out(xg), .cache_stall_out(),
        .xbar_stall_out(), .bank_busy_out(bb), .inversion_active_out(ia));
    task automatic chk(input logic [1:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // ----------------------------
    // monitor takes oldest note per grant
    // ----------------------------
    always @(negedge core_clk_in) if (mon && (cg || xg)) begin
        e = q.size() ? q.pop_front() : 2'h0;
        chk({cg, xg}, e);
    end
    task automatic go(input logic [31:0] xa, input logic [1:0] e0, e1);
        cr <= '{1'b1, a, 1'b1, {$urandom, $urandom}, 8'hff};
        xr <= '{1'b1, xa, 1'b0, 64'h0, 8'hff};
        ld <= 1'b1;
        q.push_back(e0);
        if (e1 != 2'h0) q.push_back(e1);
        @(posedge core_clk_in) ld <= 1'b0;
        repeat (4) @(posedge core_clk_in);
    endtask : go
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    initial begin
        void'($urandom(22));
        repeat (4) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        mon <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            prio <= p[0];
            repeat (3) @(posedge core_clk_in);
            for (int b = 0; b < 4; b++) begin
                a = ($urandom() & 32'hffff_ffe0) | 32'(b << 3);
                go(a ^ 32'h80, p ? 2'h1 : 2'h2, p ? 2'h2 : 2'h1);
                go(a ^ 32'h60, 2'h2, 2'h1);
                go(a ^ 32'h08, 2'h3, 2'h0);
            end
            $display("test %0d done", p);
        end
        mon <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            prio <= p[0];
            hold <= 1'b1;
            repeat (3) @(posedge core_clk_in);
            go(a ^ 32'h60, 2'h0, 2'h0);
            @(negedge core_clk_in);
            chk({1'b0, ia}, {1'b0, p[0]});
            chk(bb[3:2], 2'h2);
            for (k = 0; k < 40 && !xg; k++) @(negedge core_clk_in);
            chk({1'b0, xg}, {1'b0, p[0]});
            @(posedge core_clk_in) hold <= 1'b0;
            repeat (6) @(posedge core_clk_in);
            $display("test %0d done", p + 2);
        end
        stop_test();
    end
endmodule : tb_lrpa_arbiter
